/* File: hw/ext_bus_ctrl.sv */
// External bus cycle control with ready handshake and hold arbitration
`timescale 1ns/100ps
`include "ext_bus_map.svh"
// Summary of operation
// RULE1 - Ready polarity selectable by input
// RULE2 - Sync mode samples ready pin directly
// RULE3 - Async mode adds synchroniser, one wait minimum
// RULE4 - Async ready held one period plus setup
// RULE5 - Ready may drop after command rises
// RULE6 - Ready removed before next sample point
// RULE7 - First sample after programmed access phase
// RULE8 - Inactive ready inserts one wait, resample
// RULE9 - Active ready ends current cycle
// RULE10 - Async sample point later than sync
// RULE11 - Finish running cycle before granting hold
// RULE12 - Release: drive inactive, then float, ale low
// RULE13 - Reclaim request may rise while held
// RULE14 - Regain starts only when hold rises
// RULE15 - Hold drop without reclaim regains normally
// RULE16 - Regain: floating, then driven inactive first
// RULE17 - Access phase one to thirty-two periods
// RULE18 - Grant after release, drop at regain
// RULE19 - Reclaim request drops after bus regained
module ext_bus_ctrl #(
  parameter int ACC_W = `ACC_W
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Cycle requests from the core side
  input wire logic cyc_req_i,
  input wire logic cyc_write_i,
  input wire logic [ACC_W-1:0] access_phase_length_i,
  input wire logic want_bus_i,
  output logic cyc_busy_o,
  output logic cyc_done_o,
  // Ready handshake configuration and pin
  input wire logic rdy_active_high_i,
  input wire logic rdy_async_i,
  input wire logic ready_i,
  // Arbitration pins
  input wire logic hold_n_i,
  output logic bus_grant_out_n_o,
  output logic bus_reclaim_request_n_o,
  // Bus control pins
  output ext_bus_pkg::ctrl_type ctrl_o,
  output logic ctrl_oe_o,
  output logic bus_reference_clock_o
);
  import ext_bus_pkg::*;

  ready_sync_if rs ();
  logic [1:0] pin_meta;
  logic [1:0] next_pin_meta;
  logic hold_stg3;
  logic next_hold_stg3;
  logic hold_req;
  logic next_hold_req;
  bus_state_type state;
  bus_state_type next_state;
  logic [ACC_W:0] cnt;
  logic [ACC_W:0] next_cnt;
  logic wr_cyc;
  logic next_wr_cyc;
  ctrl_type ctrl;
  ctrl_type next_ctrl;
  logic oe;
  logic next_oe;
  logic grant;
  logic next_grant;
  logic reclaim;
  logic next_reclaim;
  logic done;
  logic next_done;
  logic clk_div;
  logic rdy_now;
  logic rdy_seen;

  function automatic logic rdy_active(input logic lvl, input logic hi);
    rdy_active = hi ? lvl : !lvl; // RULE1
  endfunction

  assign rs.raw = ready_i;
  ready_sync u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .rs(rs)
  );

  // Sync mode reads pin directly, async reads synchroniser output
  assign rdy_now = rdy_async_i ? rs.sync_lvl : ready_i; // RULE2 RULE10
  assign rdy_seen = rdy_active(rdy_now, rdy_active_high_i);

  // Hold pin synchroniser, change taken when stages 2 and 3 agree
  always_comb begin
    next_pin_meta = {pin_meta[0], hold_n_i};
    next_hold_stg3 = pin_meta[1];
    next_hold_req = hold_req;
    if (pin_meta[1] == hold_stg3) begin
      next_hold_req = !hold_stg3;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta <= 2'h3;
      hold_stg3 <= 1'b1;
      hold_req <= 1'b0;
    end else begin
      pin_meta <= next_pin_meta;
      hold_stg3 <= next_hold_stg3;
      hold_req <= next_hold_req;
    end
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_wr_cyc = wr_cyc;
    next_ctrl = '{rd_n: 1'b1, wr_n: 1'b1, ale: 1'b0};
    next_oe = oe;
    next_grant = grant;
    next_reclaim = reclaim;
    next_done = 1'b0;
    unique case (state)
      ST_IDLE: begin
        next_oe = 1'b1;
        if (hold_req) begin
          next_state = ST_REL_DRIVE; // RULE11
        end else if (cyc_req_i) begin
          // Access length field 0..31 means 1..32 periods
          next_cnt = {1'b0, access_phase_length_i} + `ACC_MIN; // RULE17
          next_wr_cyc = cyc_write_i;
          next_state = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        next_cnt = cnt - 1'b1;
        if (cnt == 1) begin
          // Async path always costs at least one wait
          next_state = rdy_async_i ? ST_WAIT : ST_DONE; // RULE3 RULE7
          if (!rdy_async_i && !rdy_seen) begin
            next_state = ST_WAIT; // RULE8
          end
        end
      end
      ST_WAIT: begin
        if (rdy_seen) begin
          next_state = ST_DONE; // RULE9
        end
      end
      ST_DONE: begin
        next_done = 1'b1;
        next_state = ST_IDLE;
      end
      ST_REL_DRIVE: begin
        next_oe = 1'b0; // RULE12
        next_grant = 1'b1; // RULE18
        next_state = ST_HELD;
      end
      ST_HELD: begin
        if (want_bus_i) begin
          next_reclaim = 1'b1; // RULE13
        end
        if (!hold_req) begin
          next_grant = 1'b0; // RULE14 RULE15 RULE18
          next_state = ST_REGAIN;
        end
      end
      ST_REGAIN: begin
        next_oe = 1'b1; // RULE16
        next_reclaim = 1'b0; // RULE19
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    // Command low exactly while access or wait is registered
    if (next_state inside {ST_ACCESS, ST_WAIT}) begin
      next_ctrl.rd_n = next_wr_cyc;
      next_ctrl.wr_n = !next_wr_cyc;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      cnt <= '0;
      wr_cyc <= 1'b0;
      ctrl <= '{rd_n: 1'b1, wr_n: 1'b1, ale: 1'b0};
      oe <= 1'b1;
      grant <= 1'b0;
      reclaim <= 1'b0;
      done <= 1'b0;
      clk_div <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      wr_cyc <= next_wr_cyc;
      ctrl <= next_ctrl;
      oe <= next_oe;
      grant <= next_grant;
      reclaim <= next_reclaim;
      done <= next_done;
      clk_div <= !clk_div;
    end
  end

  assign ctrl_o = ctrl;
  assign ctrl_oe_o = oe;
  assign bus_grant_out_n_o = !grant;
  assign bus_reclaim_request_n_o = !reclaim;
  assign cyc_done_o = done;
  assign cyc_busy_o = (state != ST_IDLE);
  assign bus_reference_clock_o = clk_div;

  grant_after_release_a: assert property (@(posedge mclk_i) // RULE12
    disable iff (!rst_n_i) $rose(grant) |-> !oe && ctrl.rd_n && ctrl.wr_n)
    else $error("grant before release");
  no_grant_mid_cycle_a: assert property (@(posedge mclk_i) // RULE11
    disable iff (!rst_n_i) grant |-> state inside {ST_HELD, ST_REGAIN,
      ST_IDLE})
    else $error("grant during cycle");
  regain_on_hold_a: assert property (@(posedge mclk_i) // RULE14
    disable iff (!rst_n_i) (state == ST_HELD && hold_req)
      |=> state != ST_REGAIN)
    else $error("regain without hold release");
  regain_drops_grant_a: assert property (@(posedge mclk_i) // RULE18
    disable iff (!rst_n_i) (state == ST_HELD && !hold_req) |=> !grant)
    else $error("grant kept at regain");
  reclaim_clears_a: assert property (@(posedge mclk_i) // RULE19
    disable iff (!rst_n_i) state == ST_REGAIN |=> !reclaim && oe)
    else $error("reclaim kept after regain");
  wait_on_not_ready_a: assert property (@(posedge mclk_i) // RULE8
    disable iff (!rst_n_i) (state == ST_WAIT && !rdy_seen)
      |=> state == ST_WAIT)
    else $error("wait not extended");
  ready_ends_cycle_a: assert property (@(posedge mclk_i) // RULE9
    disable iff (!rst_n_i) (state == ST_WAIT && rdy_seen) |=> ##1 done)
    else $error("ready did not end cycle");
  async_one_wait_a: assert property (@(posedge mclk_i) // RULE3
    disable iff (!rst_n_i) (state == ST_ACCESS && cnt == 1 && rdy_async_i)
      |=> state == ST_WAIT)
    else $error("async cycle without wait");
  access_min_a: assert property (@(posedge mclk_i) // RULE17
    disable iff (!rst_n_i) (state == ST_IDLE && !hold_req && cyc_req_i)
      |=> state == ST_ACCESS && cnt >= `ACC_MIN && cnt <= `ACC_MAX)
    else $error("access length out of range");

  // Access cycles counted apart from the down counter
  logic [ACC_W:0] acc_len;
  logic [ACC_W:0] next_acc_len;
  logic [ACC_W:0] acc_seen;
  logic [ACC_W:0] next_acc_seen;

  always_comb begin
    next_acc_len = acc_len;
    next_acc_seen = acc_seen;
    if (state == ST_IDLE && next_state == ST_ACCESS) begin
      next_acc_len = next_cnt;
      next_acc_seen = '0;
    end else if (state == ST_ACCESS) begin
      next_acc_seen = acc_seen + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_len <= '0;
      acc_seen <= '0;
    end else begin
      acc_len <= next_acc_len;
      acc_seen <= next_acc_seen;
    end
  end

  access_length_a: assert property (@(posedge mclk_i) // RULE17
    disable iff (!rst_n_i) (state == ST_ACCESS && next_state != ST_ACCESS)
      |-> acc_seen + 1'b1 == acc_len)
    else $error("access phase length wrong");
  cmd_tracks_state_a: assert property (@(posedge mclk_i) // RULE7
    disable iff (!rst_n_i)
      (ctrl.rd_n && ctrl.wr_n) == !(state inside {ST_ACCESS, ST_WAIT}))
    else $error("command not aligned with access");
  sync_ready_ends_a: assert property (@(posedge mclk_i) // RULE2
    disable iff (!rst_n_i)
      (state == ST_ACCESS && cnt == 1 && !rdy_async_i && rdy_seen)
      |=> state == ST_DONE)
    else $error("sync ready ignored");
  async_late_a: assert property (@(posedge mclk_i) // RULE10
    disable iff (!rst_n_i) (state == ST_ACCESS && rdy_async_i)
      |=> state != ST_DONE)
    else $error("async ready sampled early");
  release_order_a: assert property (@(posedge mclk_i) // RULE12
    disable iff (!rst_n_i) (state == ST_IDLE && hold_req)
      |=> (state == ST_REL_DRIVE && oe) ##1 (!oe && grant))
    else $error("release order broken");
  regain_inactive_a: assert property (@(posedge mclk_i) // RULE16
    disable iff (!rst_n_i) $rose(oe)
      |-> ctrl.rd_n && ctrl.wr_n && !ctrl.ale && state == ST_IDLE)
    else $error("controls active at regain");
  reclaim_in_held_a: assert property (@(posedge mclk_i) // RULE13
    disable iff (!rst_n_i) $rose(reclaim) |-> $past(state) == ST_HELD)
    else $error("reclaim outside hold");
  grant_drop_a: assert property (@(posedge mclk_i) // RULE15
    disable iff (!rst_n_i) $fell(grant) |-> !$past(hold_req))
    else $error("grant dropped while hold kept");
endmodule

/* File: hw/ext_bus_map.svh */
// Constants for the external bus cycle and arbitration block
`ifndef EXT_BUS_MAP_SVH
`define EXT_BUS_MAP_SVH
`define ACC_MIN 6'h01
`define ACC_MAX 6'h20
`define ACC_W 5
`define RDY_SYNC_STAGES 3
`endif

/* File: hw/ext_bus_pkg.sv */
// Types for the external bus cycle and arbitration block
package ext_bus_pkg;
  typedef enum {
    ST_IDLE, ST_ACCESS, ST_WAIT, ST_DONE,
    ST_REL_DRIVE, ST_HELD, ST_REGAIN
  } bus_state_type;
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic ale;
  } ctrl_type;
endpackage

/* File: hw/ready_sync.sv */
// Three-stage synchroniser for the ready pin
`timescale 1ns/100ps
`include "ext_bus_map.svh"
module ready_sync (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Ready path
  ready_sync_if.sync rs
);
  logic [`RDY_SYNC_STAGES-1:0] stage;
  logic [`RDY_SYNC_STAGES-1:0] next_stage;
  logic lvl;
  logic next_lvl;

  always_comb begin
    next_stage = {stage[`RDY_SYNC_STAGES-2:0], rs.raw};
    next_lvl = lvl;
    // Change accepted once second and third stages agree
    if (stage[1] == stage[2]) begin
      next_lvl = stage[2];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage <= '0;
      lvl <= 1'b0;
    end else begin
      stage <= next_stage;
      lvl <= next_lvl;
    end
  end

  assign rs.sync_lvl = lvl;
endmodule

/* File: hw/ready_sync_if.sv */
// Ready path between the bus controller and its synchroniser
`timescale 1ns/100ps
interface ready_sync_if;
  logic raw;
  logic sync_lvl;
  modport ctl (input sync_lvl, output raw);
  modport sync (input raw, output sync_lvl);
endinterface

/* File: testbench/ext_bus_ready_and_hold_arbitration_bench.sv */
// Self-checking bench for the external bus cycle and arbitration block
`timescale 1ns/100ps
module ext_bus_ready_and_hold_arbitration_bench;
  import ext_bus_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cyc_req_i = 1'b0;
  logic cyc_write_i = 1'b0;
  logic [4:0] access_phase_length_i = 5'h00;
  logic want_bus_i = 1'b0;
  logic rdy_active_high_i = 1'b1;
  logic rdy_async_i = 1'b0;
  logic hold_n_i = 1'b1;
  logic [5:0] dly = 6'h00;
  logic ready_i, cyc_busy_o, cyc_done_o, bus_grant_out_n_o;
  logic bus_reclaim_request_n_o, ctrl_oe_o, bus_reference_clock_o;
  ctrl_type ctrl_o, ctrl_w;
  logic [7:0] q[$];
  logic [7:0] note;
  logic [7:0] low_cnt = 8'h00;
  logic wr_seen = 1'b0;
  logic ref_prev = 1'b0;
  logic ref_ok = 1'b0;
  int mismatches = 0;
  int total_checks = 0;
  int dones = 0;
  always #12.5 mclk_i = ~mclk_i;
  // Released controls read high on the wire, ale stays driven low
  assign ctrl_w = ctrl_oe_o ? ctrl_o : ctrl_type'{1'b1, 1'b1, ctrl_o.ale};
  ext_bus_ctrl DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .cyc_req_i(cyc_req_i), .cyc_write_i(cyc_write_i),
    .access_phase_length_i(access_phase_length_i),
    .want_bus_i(want_bus_i), .cyc_busy_o(cyc_busy_o),
    .cyc_done_o(cyc_done_o), .rdy_active_high_i(rdy_active_high_i),
    .rdy_async_i(rdy_async_i), .ready_i(ready_i), .hold_n_i(hold_n_i),
    .bus_grant_out_n_o(bus_grant_out_n_o),
    .bus_reclaim_request_n_o(bus_reclaim_request_n_o),
    .ctrl_o(ctrl_o), .ctrl_oe_o(ctrl_oe_o),
    .bus_reference_clock_o(bus_reference_clock_o));
  ready_partner partner (.mclk_i(mclk_i), .ctrl_i(ctrl_w),
    .active_high_i(rdy_active_high_i), .delay_i(dly), .ready_o(ready_i));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic till(ref logic s, input logic v);
    int i;
    @(negedge mclk_i);
    for (i = 0; i < 300 && s !== v; i++) @(negedge mclk_i);
  endtask
  task automatic cyc(input logic [4:0] n, input logic asy,
    input logic [5:0] d);
    logic wr;
    wr = 1'($urandom);
    q.push_back({!asy && d == 6'h00, wr, 6'(n) + 6'h01});
    @(posedge mclk_i);
    cyc_req_i <= 1'b1;
    cyc_write_i <= wr;
    access_phase_length_i <= n;
    rdy_async_i <= asy;
    rdy_active_high_i <= 1'($urandom);
    dly <= d;
    till(cyc_busy_o, 1'b1);
    check(8'(cyc_busy_o), 8'h01);
    @(posedge mclk_i);
    cyc_req_i <= 1'b0;
    till(cyc_done_o, 1'b1);
    check(8'(cyc_done_o), 8'h01);
  endtask
  task automatic hold(input logic ask, input int inc);
    int d0;
    d0 = dones;
    @(posedge mclk_i);
    hold_n_i <= 1'b0;
    till(bus_grant_out_n_o, 1'b0);
    check(8'(bus_grant_out_n_o), 8'h00);
    check(8'(dones - d0), 8'(inc));
    check({6'h00, ctrl_oe_o, ctrl_w.ale}, 8'h00);
    if (ask) begin
      @(posedge mclk_i);
      want_bus_i <= 1'b1;
      till(bus_reclaim_request_n_o, 1'b0);
      check(8'(bus_reclaim_request_n_o), 8'h00);
      repeat (6) @(negedge mclk_i);
      check(8'(bus_grant_out_n_o), 8'h00);
    end
    @(posedge mclk_i);
    hold_n_i <= 1'b1;
    till(bus_grant_out_n_o, 1'b1);
    check(8'(bus_grant_out_n_o), 8'h01);
    till(ctrl_oe_o, 1'b1);
    check({ctrl_oe_o, ctrl_w}, 8'h0e);
    check(8'(bus_reclaim_request_n_o), 8'h01);
    @(posedge mclk_i);
    want_bus_i <= 1'b0;
  endtask
  // Counts command-low cycles and compares with the oldest note
  always @(posedge mclk_i) begin
    if (ref_ok) check(8'(bus_reference_clock_o), 8'(!ref_prev));
    ref_prev = bus_reference_clock_o;
    ref_ok = rst_n_i;
    if (cyc_done_o === 1'b1) dones++;
    if (ctrl_w.rd_n === 1'b0 || ctrl_w.wr_n === 1'b0) begin
      low_cnt++;
      wr_seen = !ctrl_w.wr_n;
    end else if (low_cnt != 8'h00) begin
      note = (q.size() > 0) ? q.pop_front() : 8'hxx;
      if (note[7]) check(low_cnt, {2'b00, note[5:0]});
      else check(8'(low_cnt > {2'b00, note[5:0]}), 8'h01);
      check(8'(wr_seen), 8'(note[6]));
      low_cnt = 8'h00;
    end
  end
  initial begin
    #2000000;
    mismatches++;
    results;
  end
  initial begin
    void'($urandom(54800));
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    cyc(5'h00, 1'b0, 6'h00);
    cyc(5'h1f, 1'b0, 6'h00);
    repeat (6) cyc(5'($urandom), 1'b0, 6'h00);
    cyc(5'h02, 1'b0, 6'h05);
    repeat (3) cyc(5'($urandom), 1'b1, 6'h00);
    fork
      cyc(5'h1f, 1'b0, 6'h00);
      begin
        repeat (4) @(posedge mclk_i);
        hold(1'b1, 1);
      end
    join
    hold(1'b0, 0);
    cyc(5'h03, 1'b0, 6'h00);
    results;
  end
endmodule

/* File: testbench/ready_partner.sv */
// Ready responder standing in for an external memory or peripheral
`timescale 1ns/100ps
module ready_partner (
  // Clock
  input wire logic mclk_i,
  // Bus side
  input wire ext_bus_pkg::ctrl_type ctrl_i,
  input wire logic active_high_i,
  input wire logic [5:0] delay_i,
  output logic ready_o
);
  import ext_bus_pkg::*;
  logic [5:0] low_cnt = 6'h00;
  logic cmd;
  logic go;
  assign cmd = !(ctrl_i.rd_n && ctrl_i.wr_n);
  // Active only after delay, held until command rises
  assign go = cmd && low_cnt >= delay_i;
  // Derived from registered controls, so synchronous to the clock
  assign ready_o = go == active_high_i;
  always @(posedge mclk_i) begin
    low_cnt <= cmd ? low_cnt + 6'h01 : 6'h00;
  end
endmodule
